/* rec_err_pkg.sv */
/*
 * Package for the recoverable error reporting block: register offsets,
 * status field positions, error code encodings and bus carrier structs.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
package rec_err_pkg;

    // =====================================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_STATUS_LO = 8'h00;
    localparam logic [7:0] OFF_STATUS_HI = 8'h04;
    localparam logic [7:0] OFF_MISC      = 8'h08;
    localparam logic [7:0] OFF_ADDR_LO   = 8'h0C;
    localparam logic [7:0] OFF_ADDR_HI   = 8'h10;
    localparam logic [7:0] OFF_GLOBAL    = 8'h14;
    localparam logic [7:0] OFF_CTRL      = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h1C;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h20;

    // =====================================================================
    // Bank status flag positions within the high status word (bits 63:32)
    localparam int BIT_VALID   = 31;
    localparam int BIT_OVER    = 30;
    localparam int BIT_UNCORR  = 29;
    localparam int BIT_ENABLED = 28;
    localparam int BIT_MISC_VALID_FLAG   = 27;
    localparam int BIT_ADDRESS_VALID_FLAG   = 26;
    localparam int BIT_PCC     = 25;
    localparam int BIT_SIG     = 24;
    localparam int BIT_AR      = 23;

    // Global status bit positions
    localparam int GBIT_RESTART = 0;
    localparam int GBIT_ERRPTR  = 1;
    localparam int GBIT_INPROG  = 2;
    localparam int GBIT_LOCAL   = 3;

    // Control bit positions
    localparam int CBIT_LOCAL_EN  = 0;
    localparam int CBIT_LOCAL_SUP = 1;
    localparam int CBIT_BANK_EN   = 2;

    // Interrupt status bit positions
    localparam int IBIT_LOGGED   = 0;
    localparam int IBIT_OVERFLOW = 1;

    // =====================================================================
    // Error code encodings
    localparam logic [8:0]  MC_PREFIX       = 9'h001;
    localparam logic [2:0]  MEM_SCRUB       = 3'h4;
    localparam logic [3:0]  CHANNEL_NONE    = 4'hF;
    localparam logic [15:0] CODE_WRITEBACK  = 16'h017A;
    localparam logic [15:0] CODE_DATA_LOAD  = 16'h0134;
    localparam logic [15:0] CODE_INST_FETCH = 16'h0150;

    // Misc register layout: lsb in 5:0, address mode in 8:6
    localparam logic [2:0] ADDR_MODE_PHYS = 3'h2;
    localparam int         MISC_LSB_LO    = 0;
    localparam int         MISC_MODE_LO   = 6;
    localparam logic [7:0] ADDR_HI_PAD    = 8'h00;

    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [3:0]  CTRL_RESET = 4'h4;

    // =====================================================================
    // Error kinds reported by the detecting logic
    typedef enum logic [3:0] {
        KIND_SCRUB     = 4'b0001,
        KIND_WRITEBACK = 4'b0010,
        KIND_LOAD      = 4'b0100,
        KIND_FETCH     = 4'b1000
    } err_kind_t;

    // Error report from the detecting logic
    typedef struct packed {
        err_kind_t   kind;
        logic [3:0]  channel;
        logic [39:0] phys_addr;
        logic [5:0]  addr_lsb;
        logic        continuable;
        logic        affected;
    } err_report_t;

    // Wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

endpackage

/* rec_err_report.sv */
/*
 * Recoverable error reporting bank: classifies four uncorrected recoverable
 * errors, logs code, flags, misc and address, sets restart and error pointer
 * flags in the global status and chooses broadcast or local delivery.
 * Assumes one clock, synchronous inputs and a classic Wishbone master.
 */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Scrubbing error code: prefix 0000_0000_1, type 100, channel or generic
// - Writeback error code is 17A: eviction, generic, level 2
// - Data load error code is 134: data read, data, level 0
// - Instruction fetch error code is 150: fetch, instruction, level 0
// - Optional-recovery errors log flags with action-required clear
// - Required-recovery errors log the same flags with action-required set
// - Scrub and writeback errors fill address and misc registers
// - Load and fetch errors also fill address and misc registers
// - Misc holds physical address mode 010 and lowest valid address bit
// - Exception broadcasts unless local delivery is supported and enabled
// - Global status shows whether exception went only to this processor
// - A shared bank may show an error some processors never see
// - Optional-recovery errors give restart valid 1, error pointer 0
// - Affected processor: continuable gives 1,1; otherwise restart 0
// - Unaffected observers of required-recovery errors show restart 1, pointer 0
// - Channel 1111 means unspecified; 0000 to 1110 name a channel
module rec_err_report
    import rec_err_pkg::*;
(
    input  wire logic        ref_clk,     // 20 MHz clock
    input  wire logic        rst,         // Async reset, active high
    input  wire logic        clk_en,      // Freezes all state when low
    input  wire logic        err_valid,   // Error report strobe
    input  wire err_report_t err_in,      // Error report contents
    input  wire logic        wb_cyc_i,    // Wishbone cycle
    input  wire logic        wb_stb_i,    // Wishbone strobe
    input  wire logic        wb_we_i,     // Wishbone write enable
    input  wire logic [3:0]  wb_sel_i,    // Wishbone byte selects
    input  wire logic [7:0]  wb_adr_i,    // Wishbone byte address
    input  wire logic [31:0] wb_dat_i,    // Wishbone write data
    output logic [31:0]      wb_dat_o,    // Wishbone read data
    output logic             wb_ack_o,    // Wishbone acknowledge
    output logic             mce_bcast_q, // Exception to all processors
    output logic             mce_local_q, // Exception to this processor only
    output logic             irq_q        // Level interrupt
);

    // =====================================================================
    // Local state
    logic [31:0] status_lo_q;
    logic [31:0] status_hi_q;
    logic [31:0] misc_q;
    logic [39:0] addr_q;
    logic [3:0]  global_q;
    logic [3:0]  ctrl_q;
    logic [1:0]  irq_stat_q;
    logic [1:0]  irq_mask_q;
    wb_req_t     req;
    logic        wr_stb;
    logic        rd_stb;
    logic        log_evt;
    logic        ovf_evt;
    logic [15:0] code_d;
    logic        optional_err;
    logic        local_del;

    assign req    = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                      adr: wb_adr_i, dat: wb_dat_i};
    assign wr_stb = clk_en && req.cyc && req.stb && req.we && !wb_ack_o;
    assign rd_stb = clk_en && req.cyc && req.stb && !req.we && !wb_ack_o;

    // =====================================================================
    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Compose the error code for a reported kind
    function automatic logic [15:0] compose(input err_kind_t k, input logic [3:0] ch);
        case (k)
            KIND_SCRUB:     compose = {MC_PREFIX, MEM_SCRUB, ch};
            KIND_WRITEBACK: compose = CODE_WRITEBACK;
            KIND_LOAD:      compose = CODE_DATA_LOAD;
            KIND_FETCH:     compose = CODE_INST_FETCH;
            default:        compose = CODE_WRITEBACK;
        endcase
    endfunction

    assign code_d       = compose(err_in.kind, err_in.channel);
    assign optional_err = (err_in.kind == KIND_SCRUB) || (err_in.kind == KIND_WRITEBACK);
    assign log_evt      = clk_en && err_valid && ctrl_q[CBIT_BANK_EN] && !status_hi_q[BIT_VALID];
    assign ovf_evt      = clk_en && err_valid && ctrl_q[CBIT_BANK_EN] && status_hi_q[BIT_VALID];
    assign local_del    = ctrl_q[CBIT_LOCAL_SUP] && ctrl_q[CBIT_LOCAL_EN];

    // =====================================================================
    // Bank status, misc and address logging
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_lo_q <= ZERO32;
            status_hi_q <= ZERO32;
            misc_q      <= ZERO32;
            addr_q      <= '0;
        end else if (log_evt) begin
            status_lo_q              <= {16'h0000, code_d};
            status_hi_q              <= ZERO32;
            status_hi_q[BIT_VALID]   <= 1'b1;
            status_hi_q[BIT_UNCORR]  <= 1'b1;
            status_hi_q[BIT_ENABLED] <= 1'b1;
            status_hi_q[BIT_MISC_VALID_FLAG]   <= 1'b1;
            status_hi_q[BIT_ADDRESS_VALID_FLAG]   <= 1'b1;
            status_hi_q[BIT_SIG]     <= 1'b1;
            status_hi_q[BIT_AR]      <= !optional_err;
            misc_q                   <= ZERO32;
            misc_q[MISC_MODE_LO +: 3] <= ADDR_MODE_PHYS;
            misc_q[MISC_LSB_LO +: 6]  <= err_in.addr_lsb;
            addr_q                   <= err_in.phys_addr;
        end else if (ovf_evt) begin
            status_hi_q[BIT_OVER] <= 1'b1;
        end else if (wr_stb && req.adr == OFF_STATUS_HI) begin
            // Software clears the shared bank; other processors may never see it
            status_hi_q <= merge(status_hi_q, req.dat, req.sel);
        end
    end

    // =====================================================================
    // Global restart and error pointer flags, exception delivery
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            global_q    <= 4'h0;
            mce_bcast_q <= 1'b0;
            mce_local_q <= 1'b0;
        end else if (clk_en) begin
            mce_bcast_q <= 1'b0;
            mce_local_q <= 1'b0;
            if (err_valid && ctrl_q[CBIT_BANK_EN]) begin
                global_q[GBIT_INPROG] <= 1'b1;
                global_q[GBIT_LOCAL]  <= local_del;
                mce_bcast_q           <= !local_del;
                mce_local_q           <= local_del;
                if (optional_err) begin
                    global_q[GBIT_RESTART] <= 1'b1;
                    global_q[GBIT_ERRPTR]  <= 1'b0;
                end else if (!err_in.affected) begin
                    global_q[GBIT_RESTART] <= 1'b1;
                    global_q[GBIT_ERRPTR]  <= 1'b0;
                end else begin
                    // Non-continuable keeps pointer set; resume needs a fix first
                    global_q[GBIT_RESTART] <= err_in.continuable;
                    global_q[GBIT_ERRPTR]  <= 1'b1;
                end
            end else if (wr_stb && req.adr == OFF_GLOBAL && req.sel[0]) begin
                global_q <= req.dat[3:0];
            end
        end
    end

    // =====================================================================
    // Control and interrupt registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q     <= CTRL_RESET;
            irq_mask_q <= 2'h0;
        end else if (wr_stb && req.sel[0]) begin
            if (req.adr == OFF_CTRL) begin
                ctrl_q <= req.dat[3:0];
            end
            if (req.adr == OFF_IRQ_MASK) begin
                irq_mask_q <= req.dat[1:0];
            end
        end
    end

    // Sticky events; a new event wins over a write-one clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= 2'h0;
        end else if (clk_en) begin
            irq_stat_q <= (irq_stat_q & ~((wr_stb && req.adr == OFF_IRQ_STAT && req.sel[0])
                                          ? req.dat[1:0] : 2'h0))
                          | {ovf_evt, log_evt};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // =====================================================================
    // Wishbone answer: one wait state, unmapped addresses read zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= ZERO32;
        end else if (clk_en) begin
            wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
            if (rd_stb) begin
                case (req.adr)
                    OFF_STATUS_LO: wb_dat_o <= status_lo_q;
                    OFF_STATUS_HI: wb_dat_o <= status_hi_q;
                    OFF_MISC:      wb_dat_o <= misc_q;
                    OFF_ADDR_LO:   wb_dat_o <= addr_q[31:0];
                    OFF_ADDR_HI:   wb_dat_o <= {16'h0000, ADDR_HI_PAD, addr_q[39:32]};
                    OFF_GLOBAL:    wb_dat_o <= {28'h0000000, global_q};
                    OFF_CTRL:      wb_dat_o <= {28'h0000000, ctrl_q};
                    OFF_IRQ_STAT:  wb_dat_o <= {30'h00000000, irq_stat_q};
                    OFF_IRQ_MASK:  wb_dat_o <= {30'h00000000, irq_mask_q};
                    default:       wb_dat_o <= ZERO32;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* rec_err_report_asserts.sv */
/*
 * Checker for rec_err_report: bus handshake, exception delivery, interrupt
 * cause and logged values. Bound to the top module and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
module rec_err_report_asserts
    import rec_err_pkg::*;
(
    input wire logic        ref_clk,     // Clock
    input wire logic        rst,         // Async reset
    input wire logic        clk_en,      // Run enable
    input wire logic        err_valid,   // Error strobe
    input wire logic        wb_cyc_i,    // Bus cycle
    input wire logic        wb_stb_i,    // Bus strobe
    input wire logic        wb_we_i,     // Bus write
    input wire logic [3:0]  wb_sel_i,    // Byte selects
    input wire logic [7:0]  wb_adr_i,    // Byte address
    input wire logic [31:0] wb_dat_i,    // Write data
    input wire logic [31:0] wb_dat_o,    // Read data
    input wire logic        wb_ack_o,    // Acknowledge
    input wire logic        mce_bcast_q, // Broadcast exception
    input wire logic        mce_local_q, // Local exception
    input wire logic        irq_q        // Interrupt
);
    // =========================================================
    // Shadow of the control register
    logic [2:0] ctrl_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            ctrl_q <= CTRL_RESET[2:0];
        else if (clk_en && wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == OFF_CTRL && wb_sel_i[0])
            ctrl_q <= wb_dat_i[2:0];
    end
    wire logic take = err_valid && clk_en && ctrl_q[CBIT_BANK_EN];
    wire logic loc  = ctrl_q[CBIT_LOCAL_EN] && ctrl_q[CBIT_LOCAL_SUP];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // =========================================================
    // Properties
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
    property p_ack_drop; wb_ack_o && clk_en |=> !wb_ack_o; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack held too long");
    property p_bcast; take && !loc |=> mce_bcast_q && !mce_local_q; endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast exception wrong");
    property p_local; take && loc |=> mce_local_q && !mce_bcast_q; endproperty
    a_local: assert property (p_local) else $error("local exception wrong");
    property p_quiet; clk_en && !take |=> !mce_bcast_q && !mce_local_q; endproperty
    a_quiet: assert property (p_quiet) else $error("exception without error");
    property p_irq_cause;
        $rose(irq_q) |-> $past(mce_bcast_q || mce_local_q) || $past(wb_ack_o && wb_we_i);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
    property p_code;
        wb_ack_o && !wb_we_i && wb_adr_i == OFF_STATUS_LO |-> wb_dat_o[15:4] == 12'h00C
            || wb_dat_o[15:0] inside {16'h0000, 16'h017A, 16'h0134, 16'h0150};
    endproperty
    a_code: assert property (p_code) else $error("error code not legal");
    property p_flags;
        wb_ack_o && !wb_we_i && wb_adr_i == OFF_STATUS_HI && wb_dat_o[BIT_VALID] |-> wb_dat_o[29:24] == 6'h3D;
    endproperty
    a_flags: assert property (p_flags) else $error("status flags wrong");
    property p_misc;
        wb_ack_o && !wb_we_i && wb_adr_i == OFF_MISC && wb_dat_o != ZERO32 |-> wb_dat_o[8:6] == 3'h2;
    endproperty
    a_misc: assert property (p_misc) else $error("address mode wrong");
endmodule
bind rec_err_report rec_err_report_asserts i_chk (.ref_clk, .rst, .clk_en, .err_valid, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mce_bcast_q, .mce_local_q, .irq_q);
`default_nettype wire

/* rec_err_report_bench.sv */
/*
 * Self-checking bench for rec_err_report: register tasks on the bus and
 * error injection. Assumes the package constants and a 20 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module rec_err_report_bench
    import rec_err_pkg::*;
;
    logic        ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, err_valid = 1'b0;
    err_report_t err_in = '0;
    wb_req_t     req = '0;
    logic [31:0] wb_dat_o, rd;
    logic [15:0] code;
    logic        wb_ack_o, mce_bcast_q, mce_local_q, irq_q, rq;
    int          failures = 0, n_tests = 0;
    err_kind_t   kinds[6] = '{KIND_SCRUB, KIND_SCRUB, KIND_WRITEBACK, KIND_LOAD, KIND_FETCH, KIND_LOAD};
    always #25 ref_clk = ~ref_clk;
    rec_err_report i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .err_valid(err_valid),
        .err_in(err_in), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel),
        .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .mce_bcast_q(mce_bcast_q), .mce_local_q(mce_local_q), .irq_q(irq_q));
    // =========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{1'b1, 1'b1, we, 4'hF, a, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        req <= '0;
        if (n >= 20) failures++;
    endtask
    task automatic fire(input err_kind_t k, input logic [3:0] ch, input logic c, input logic a);
        @(posedge ref_clk);
        err_valid <= 1'b1;
        err_in <= '{k, ch, 40'hA5_1234_5678, 6'h06, c, a};
        @(posedge ref_clk);
        err_valid <= 1'b0;
        #1;
    endtask
    task automatic clear_log();
        bus(1'b1, OFF_STATUS_HI, ZERO32);
        bus(1'b1, OFF_IRQ_STAT, 32'h0000_0003);
        bus(1'b0, OFF_IRQ_STAT, ZERO32);
        chk({rd[1:0], irq_q}, 3'h0);
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // =========================================================
    // Tests
    initial begin
        #1000000;
        failures++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        bus(1'b0, OFF_CTRL, ZERO32);
        chk(32'(rd[2:0]), 32'h0000_0004);
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        bus(1'b0, 8'h40, ZERO32);
        chk(rd, ZERO32);
        $display("reset and unmapped done");
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_0003);
        for (int i = 0; i < 6; i++) begin
            rq = kinds[i] inside {KIND_LOAD, KIND_FETCH};
            fire(kinds[i], (i == 1) ? 4'hF : 4'h3, i == 3, i != 5);
            chk(32'({mce_bcast_q, mce_local_q}), 32'h2);
            @(posedge ref_clk);
            #1 chk(32'(irq_q), 32'h1);
            code = (i < 2) ? {12'h00C, (i == 1) ? 4'hF : 4'h3} : (i == 2) ? 16'h017A : (i == 4) ? 16'h0150 : 16'h0134;
            bus(1'b0, OFF_STATUS_LO, ZERO32);
            chk(32'(rd[15:0] & 16'hEFFF), 32'(code));
            bus(1'b0, OFF_STATUS_HI, ZERO32);
            chk(32'(rd[31:23]), {23'h0, 8'hBD, rq});
            bus(1'b0, OFF_MISC, ZERO32);
            chk(rd, 32'h0000_0086);
            bus(1'b0, OFF_ADDR_LO, ZERO32);
            chk(rd, 32'h1234_5678);
            bus(1'b0, OFF_ADDR_HI, ZERO32);
            chk(rd, 32'h0000_00A5);
            bus(1'b0, OFF_GLOBAL, ZERO32);
            chk(32'({rd[3], rd[1:0]}), (i == 3) ? 32'h3 : (i == 4) ? 32'h2 : 32'h1);
            clear_log();
        end
        $display("error kinds done");
        fire(KIND_SCRUB, 4'h3, 1'b0, 1'b1);
        fire(KIND_LOAD, 4'h3, 1'b1, 1'b1);
        bus(1'b0, OFF_STATUS_LO, ZERO32);
        chk(32'(rd[15:0]), 32'h0000_00C3);
        bus(1'b0, OFF_STATUS_HI, ZERO32);
        chk(32'(rd[31:30]), 32'h3);
        bus(1'b0, OFF_IRQ_STAT, ZERO32);
        chk(32'(rd[1:0]), 32'h3);
        clear_log();
        $display("overflow done");
        bus(1'b1, OFF_CTRL, 32'h0000_0007);
        fire(KIND_FETCH, 4'h3, 1'b1, 1'b1);
        chk(32'({mce_bcast_q, mce_local_q}), 32'h1);
        bus(1'b0, OFF_GLOBAL, ZERO32);
        chk(32'(rd[3]), 32'h1);
        clear_log();
        bus(1'b1, OFF_CTRL, ZERO32);
        fire(KIND_LOAD, 4'h3, 1'b1, 1'b1);
        chk(32'({mce_bcast_q, mce_local_q}), 32'h0);
        bus(1'b1, OFF_CTRL, 32'h0000_0004);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        fire(KIND_LOAD, 4'h3, 1'b1, 1'b1);
        chk(32'({mce_bcast_q, mce_local_q}), 32'h0);
        clk_en <= 1'b1;
        bus(1'b0, OFF_STATUS_HI, ZERO32);
        chk(32'(rd[BIT_VALID]), 32'h0);
        $display("delivery and gating done");
        bus(1'b1, OFF_IRQ_MASK, ZERO32);
        fire(KIND_SCRUB, 4'hF, 1'b0, 1'b1);
        bus(1'b0, OFF_IRQ_STAT, ZERO32);
        chk(32'({rd[0], irq_q}), 32'h2);
        clear_log();
        $display("mask done");
        close_out();
    end
endmodule
`default_nettype wire
